// ### ppcs_map.svh
`ifndef PPCS_MAP_SVH
`define PPCS_MAP_SVH
// Register addresses (register index on the management port).
`define PPCS_P1_FORCE_ADV   8'h1C
`define PPCS_P1_MISC        8'h1D
`define PPCS_P1_STATUS      8'h1E
`define PPCS_P2_FORCE_ADV   8'h2C
`define PPCS_P2_MISC        8'h2D
`define PPCS_P2_STATUS      8'h2E
`define PPCS_P3_MISC_RSVD   8'h3D
`define PPCS_P3_STAT_RSVD   8'h3E
// Force/advertise register fields.
`define PPCS_AN_EN_BIT      7
`define PPCS_FSPD_BIT       6
`define PPCS_FDPX_BIT       5
`define PPCS_ADV_MSB        4
`define PPCS_FORCE_ADV_RST  8'hFF
// Misc control register fields.
`define PPCS_LED_OFF_BIT    7
`define PPCS_TXDIS_BIT      6
`define PPCS_RESTART_BIT    5
`define PPCS_FEF_DIS_BIT    4
`define PPCS_PWRDN_BIT      3
`define PPCS_AMDIX_DIS_BIT  2
`define PPCS_FMDI_BIT       1
`define PPCS_LOOP_BIT       0
`define PPCS_MISC_RST       8'h00
// Status register fields.
`define PPCS_ST_MDI_BIT     7
`define PPCS_ST_AND_BIT     6
`define PPCS_ST_LINK_BIT    5
`define PPCS_STATUS_RST     8'h00
`endif

// ### ppcs_pkg.sv
package ppcs_pkg;
  typedef logic [7:0] ppcs_byte_t;
  typedef logic [1:0] ppcs_port_vec_t;
  typedef enum logic [1:0] {
    PPCS_ACC_IDLE  = 2'b01,
    PPCS_ACC_WRITE = 2'b10
  } ppcs_acc_t;
endpackage

// ### ppcs_regs.sv
`timescale 1ns/1ns
`include "ppcs_map.svh"
module ppcs_regs (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Management register port
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire ppcs_pkg::ppcs_byte_t    reg_addr,
  input  wire ppcs_pkg::ppcs_byte_t    reg_wdata,
  output logic [7:0]                   reg_rdata,
  output logic                         reg_rvalid,
  // PHY analogue side status, per port (index 0 is port 1)
  input  wire ppcs_pkg::ppcs_port_vec_t phy_mdi_state,
  input  wire ppcs_pkg::ppcs_port_vec_t phy_an_done,
  input  wire ppcs_pkg::ppcs_port_vec_t phy_link_good,
  input  wire logic [9:0]              phy_partner_abil,
  input  wire ppcs_pkg::ppcs_port_vec_t port_led_in_a,
  input  wire ppcs_pkg::ppcs_port_vec_t port_led_in_b,
  // PHY controls, per port
  output logic [1:0]                   phy_an_enable,
  output logic [1:0]                   phy_speed_100,
  output logic [1:0]                   phy_full_duplex,
  output logic [9:0]                   phy_advertise,
  output logic [1:0]                   port_led_output_a,
  output logic [1:0]                   port_led_output_b,
  output logic [1:0]                   phy_tx_disable,
  output logic [1:0]                   phy_an_restart,
  output logic [1:0]                   phy_fef_enable,
  output logic [1:0]                   phy_power_down,
  output logic [1:0]                   phy_auto_mdix,
  output logic [1:0]                   phy_force_mdi,
  output logic [1:0]                   phy_loopback
);
  import ppcs_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  ppcs_byte_t force_adv [2];
  ppcs_byte_t misc      [2];
  ppcs_byte_t status    [2];
  ppcs_byte_t next_rdata;

  // Maps an address to a PHY port index; only ports 1 and 2 decode.
  function automatic logic port_hit(input ppcs_byte_t a, input ppcs_byte_t p1,
                                    input ppcs_byte_t p2, output logic idx);
    idx = (a == p2);
    return (a == p1) || (a == p2);
  endfunction

  logic fa_hit, mi_hit, st_hit;
  logic fa_idx, mi_idx, st_idx;
  always_comb begin
    fa_hit = port_hit(reg_addr, `PPCS_P1_FORCE_ADV, `PPCS_P2_FORCE_ADV, fa_idx);
    mi_hit = port_hit(reg_addr, `PPCS_P1_MISC, `PPCS_P2_MISC, mi_idx);
    st_hit = port_hit(reg_addr, `PPCS_P1_STATUS, `PPCS_P2_STATUS, st_idx);
  end

  // ----------------------------------------------------------------
  // Control register writes
  // ----------------------------------------------------------------
  // The reserved third-port addresses never decode, so writes there are dropped.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      force_adv[0] <= `PPCS_FORCE_ADV_RST;
      force_adv[1] <= `PPCS_FORCE_ADV_RST;
    end else if (reg_wr && fa_hit) begin
      force_adv[fa_idx] <= reg_wdata;
    end
  end

  // Restart is a self-clearing command: it reads back zero once acted on.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      misc[0] <= `PPCS_MISC_RST;
      misc[1] <= `PPCS_MISC_RST;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (reg_wr && mi_hit && (mi_idx == p[0])) begin
          misc[p] <= reg_wdata;
        end else begin
          misc[p][`PPCS_RESTART_BIT] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Status capture
  // ----------------------------------------------------------------
  // Inputs come from the PHY analogue side, so they pass two flops first.
  ppcs_byte_t st_sync1 [2];
  ppcs_port_vec_t led_a_s1, led_a_s2, led_b_s1, led_b_s2;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int p = 0; p < 2; p++) begin
        st_sync1[p] <= `PPCS_STATUS_RST;
        status[p]   <= `PPCS_STATUS_RST;
      end
    end else begin
      for (int p = 0; p < 2; p++) begin
        st_sync1[p] <= {phy_mdi_state[p], phy_an_done[p], phy_link_good[p],
                        phy_partner_abil[p*5 +: 5]};
        status[p]   <= st_sync1[p];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      led_a_s1 <= 2'h0;
      led_a_s2 <= 2'h0;
      led_b_s1 <= 2'h0;
      led_b_s2 <= 2'h0;
    end else begin
      led_a_s1 <= port_led_in_a;
      led_a_s2 <= led_a_s1;
      led_b_s1 <= port_led_in_b;
      led_b_s2 <= led_b_s1;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Reserved and unmapped addresses read as zero.
  always_comb begin
    next_rdata = 8'h00;
    if (fa_hit) begin
      next_rdata = force_adv[fa_idx];
    end else if (mi_hit) begin
      next_rdata = misc[mi_idx];
    end else if (st_hit) begin
      next_rdata = status[st_idx];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= reg_rd ? next_rdata : 8'h00;
      reg_rvalid <= reg_rd;
    end
  end

  // ----------------------------------------------------------------
  // PHY control outputs
  // ----------------------------------------------------------------
  // With negotiation on, the forced values still act as the fallback
  // if negotiation fails; the PHY applies them in that case.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phy_an_enable     <= 2'h3;
      phy_speed_100     <= 2'h3;
      phy_full_duplex   <= 2'h3;
      phy_advertise     <= 10'h3FF;
      port_led_output_a <= 2'h3;
      port_led_output_b <= 2'h3;
      phy_tx_disable    <= 2'h0;
      phy_an_restart    <= 2'h0;
      phy_fef_enable    <= 2'h3;
      phy_power_down    <= 2'h0;
      phy_auto_mdix     <= 2'h3;
      phy_force_mdi     <= 2'h0;
      phy_loopback      <= 2'h0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        phy_an_enable[p]   <= force_adv[p][`PPCS_AN_EN_BIT];
        phy_speed_100[p]   <= force_adv[p][`PPCS_FSPD_BIT];
        phy_full_duplex[p] <= force_adv[p][`PPCS_FDPX_BIT];
        phy_advertise[p*5 +: 5] <= force_adv[p][`PPCS_ADV_MSB:0];
        port_led_output_a[p] <= misc[p][`PPCS_LED_OFF_BIT] | led_a_s2[p];
        port_led_output_b[p] <= misc[p][`PPCS_LED_OFF_BIT] | led_b_s2[p];
        phy_tx_disable[p]  <= misc[p][`PPCS_TXDIS_BIT];
        phy_an_restart[p]  <= misc[p][`PPCS_RESTART_BIT];
        phy_fef_enable[p]  <= ~misc[p][`PPCS_FEF_DIS_BIT];
        phy_power_down[p]  <= misc[p][`PPCS_PWRDN_BIT];
        phy_auto_mdix[p]   <= ~misc[p][`PPCS_AMDIX_DIS_BIT];
        phy_force_mdi[p]   <= misc[p][`PPCS_FMDI_BIT];
        phy_loopback[p]    <= misc[p][`PPCS_LOOP_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_p1_misc_wr;
    reg_wr && reg_addr == `PPCS_P1_MISC;
  endsequence

  sequence s_p2_misc_wr;
    reg_wr && reg_addr == `PPCS_P2_MISC;
  endsequence

  sequence s_p1_fadv_wr;
    reg_wr && reg_addr == `PPCS_P1_FORCE_ADV;
  endsequence

  sequence s_p2_fadv_wr;
    reg_wr && reg_addr == `PPCS_P2_FORCE_ADV;
  endsequence

  AST_LED_OFF_HIGH: assert property (@(posedge clk) disable iff (rst)
    (s_p1_misc_wr and reg_wdata[7]) |-> ##2 port_led_output_a[0] && port_led_output_b[0])
    else $error("LED not driven high after LED-off write");
  AST_TXDIS: assert property (@(posedge clk) disable iff (rst)
    s_p1_misc_wr |-> ##2 phy_tx_disable[0] == $past(reg_wdata[6], 2))
    else $error("Transmit disable does not follow write");
  AST_RESTART_PULSE: assert property (@(posedge clk) disable iff (rst)
    (s_p1_misc_wr and reg_wdata[5]) ##1 !(reg_wr && reg_addr == `PPCS_P1_MISC)
      |-> ##1 phy_an_restart[0] ##1 !phy_an_restart[0])
    else $error("Restart pulse wrong");
  AST_FEF: assert property (@(posedge clk) disable iff (rst)
    s_p1_misc_wr |-> ##2 phy_fef_enable[0] == !$past(reg_wdata[4], 2))
    else $error("Far-end fault enable wrong");
  AST_MDIX: assert property (@(posedge clk) disable iff (rst)
    s_p1_misc_wr |-> ##2 phy_auto_mdix[0] == !$past(reg_wdata[2], 2))
    else $error("Auto crossover enable wrong");
  AST_FMDI: assert property (@(posedge clk) disable iff (rst)
    s_p1_misc_wr |-> ##2 phy_force_mdi[0] == $past(reg_wdata[1], 2))
    else $error("Forced MDI wrong");
  AST_LOOP: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == `PPCS_P2_MISC |-> ##2 phy_loopback[1] == $past(reg_wdata[0], 2))
    else $error("Loopback wrong");
  AST_FORCE: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == `PPCS_P1_FORCE_ADV |-> ##2
      phy_speed_100[0] == $past(reg_wdata[6], 2) && phy_full_duplex[0] == $past(reg_wdata[5], 2))
    else $error("Forced speed or duplex wrong");
  AST_STATUS: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == `PPCS_P1_STATUS |=> reg_rvalid && reg_rdata == $past(status[0]))
    else $error("Status read wrong");
  AST_RSVD: assert property (@(posedge clk) disable iff (rst)
    reg_rd && (reg_addr == `PPCS_P3_MISC_RSVD || reg_addr == `PPCS_P3_STAT_RSVD)
      |=> reg_rdata == 8'h00)
    else $error("Reserved register not zero");
  AST_AN_ENABLE: assert property (@(posedge clk) disable iff (rst)
    s_p1_fadv_wr |-> ##2 phy_an_enable[0] == $past(reg_wdata[7], 2))
    else $error("Negotiation enable does not follow write");
  AST_ADVERTISE: assert property (@(posedge clk) disable iff (rst)
    s_p1_fadv_wr |-> ##2 phy_advertise[4:0] == $past(reg_wdata[4:0], 2))
    else $error("Advertised abilities do not follow write");
  AST_P2_FORCE: assert property (@(posedge clk) disable iff (rst)
    s_p2_fadv_wr |-> ##2 phy_an_enable[1] == $past(reg_wdata[7], 2)
      && phy_speed_100[1] == $past(reg_wdata[6], 2)
      && phy_full_duplex[1] == $past(reg_wdata[5], 2))
    else $error("Port 2 forced mode wrong");
  AST_P2_ADVERTISE: assert property (@(posedge clk) disable iff (rst)
    s_p2_fadv_wr |-> ##2 phy_advertise[9:5] == $past(reg_wdata[4:0], 2))
    else $error("Port 2 advertised abilities wrong");
  AST_P2_LED_OFF: assert property (@(posedge clk) disable iff (rst)
    (s_p2_misc_wr and reg_wdata[7]) |-> ##2 port_led_output_a[1] && port_led_output_b[1])
    else $error("Port 2 LED not driven high after LED-off write");
  AST_P2_TXDIS: assert property (@(posedge clk) disable iff (rst)
    s_p2_misc_wr |-> ##2 phy_tx_disable[1] == $past(reg_wdata[6], 2))
    else $error("Port 2 transmit disable does not follow write");
  AST_P2_RESTART: assert property (@(posedge clk) disable iff (rst)
    (s_p2_misc_wr and reg_wdata[5]) ##1 !(reg_wr && reg_addr == `PPCS_P2_MISC)
      |-> ##1 phy_an_restart[1] ##1 !phy_an_restart[1])
    else $error("Port 2 restart pulse wrong");
  AST_P2_FEF: assert property (@(posedge clk) disable iff (rst)
    s_p2_misc_wr |-> ##2 phy_fef_enable[1] == !$past(reg_wdata[4], 2))
    else $error("Port 2 far-end fault enable wrong");
  AST_P2_MDIX: assert property (@(posedge clk) disable iff (rst)
    s_p2_misc_wr |-> ##2 phy_auto_mdix[1] == !$past(reg_wdata[2], 2))
    else $error("Port 2 auto crossover enable wrong");
  AST_P2_FMDI: assert property (@(posedge clk) disable iff (rst)
    s_p2_misc_wr |-> ##2 phy_force_mdi[1] == $past(reg_wdata[1], 2))
    else $error("Port 2 forced MDI wrong");
  AST_P1_LOOP: assert property (@(posedge clk) disable iff (rst)
    s_p1_misc_wr |-> ##2 phy_loopback[0] == $past(reg_wdata[0], 2))
    else $error("Port 1 loopback wrong");
  AST_P2_STATUS: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == `PPCS_P2_STATUS |=> reg_rvalid && reg_rdata == $past(status[1]))
    else $error("Port 2 status read wrong");
  // Status only tracks the pins once both sync stages hold post-reset samples.
  AST_P1_TRACK: assert property (@(posedge clk) disable iff (rst)
    !$past(rst, 2) |-> status[0] == $past({phy_mdi_state[0], phy_an_done[0],
      phy_link_good[0], phy_partner_abil[4:0]}, 2))
    else $error("Port 1 status does not track the PHY");
  AST_P2_TRACK: assert property (@(posedge clk) disable iff (rst)
    !$past(rst, 2) |-> status[1] == $past({phy_mdi_state[1], phy_an_done[1],
      phy_link_good[1], phy_partner_abil[9:5]}, 2))
    else $error("Port 2 status does not track the PHY");
  // The restart bits are masked, since they clear themselves regardless of the bus.
  AST_CTRL_KEPT: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr != `PPCS_P1_FORCE_ADV && reg_addr != `PPCS_P2_FORCE_ADV
      && reg_addr != `PPCS_P1_MISC && reg_addr != `PPCS_P2_MISC
      |=> $stable({force_adv[1], force_adv[0]}) && $stable({misc[1], misc[0]} & 16'hDFDF))
    else $error("Control changed by a write to a non-control address");
endmodule

// ### ppcs_link_partner.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Behavioural far end and analogue side of both copper ports
// ----------------------------------------------------------------
module ppcs_link_partner #(
  parameter int         AN_CYC = 20,
  parameter logic [9:0] ABIL   = 10'h3AF
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Controls from the block
  input  wire logic [1:0] an_restart,
  input  wire logic [1:0] tx_disable,
  input  wire logic [1:0] auto_mdix,
  input  wire logic [1:0] force_mdi,
  // Status towards the block
  output logic [1:0]      mdi_state,
  output logic [1:0]      an_done,
  output logic [1:0]      link_good,
  output logic [9:0]      partner_abil,
  output logic [1:0]      led_a,
  output logic [1:0]      led_b
);
  int cnt [2];

  // A silent transmitter or a restart drops the link, so the bench can see status move.
  always_ff @(posedge clk or posedge rst) begin
    for (int p = 0; p < 2; p++) begin
      if (rst || an_restart[p] || tx_disable[p]) begin
        cnt[p]       <= AN_CYC;
        an_done[p]   <= 1'b0;
        link_good[p] <= 1'b0;
      end else if (cnt[p] != 0) begin
        cnt[p] <= cnt[p] - 1;
      end else begin
        an_done[p]   <= 1'b1;
        link_good[p] <= 1'b1;
      end
      mdi_state[p] <= auto_mdix[p] ? p[0] : force_mdi[p];
    end
  end

  // Abilities are only known while the link is up; LEDs are active low.
  assign partner_abil = {link_good[1] ? ABIL[9:5] : 5'h00,
                         link_good[0] ? ABIL[4:0] : 5'h00};
  assign led_a = ~link_good;
  assign led_b = ~an_done;
endmodule

// ### phy_port_control_status_regs_tb.sv
`timescale 1ns/1ns
`include "ppcs_map.svh"
module phy_port_control_status_regs_tb;
  import ppcs_pkg::*;
  logic           clk, rst, reg_wr, reg_rd, reg_rvalid;
  ppcs_byte_t     reg_addr, reg_wdata, fa [2], mi [2];
  logic [7:0]     reg_rdata;
  ppcs_port_vec_t mdi, an, lk, la, lb;
  logic [9:0]     abil, adv;
  logic [1:0]     an_en, spd, dpx, led_a, led_b, txd, rsa, fef, pd, amdx, fmdi, lpb;
  int             err_count, checks_done, n;

  ppcs_regs uut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .phy_mdi_state(mdi), .phy_an_done(an), .phy_link_good(lk), .phy_partner_abil(abil),
    .port_led_in_a(la), .port_led_in_b(lb), .phy_an_enable(an_en), .phy_speed_100(spd),
    .phy_full_duplex(dpx), .phy_advertise(adv), .port_led_output_a(led_a),
    .port_led_output_b(led_b), .phy_tx_disable(txd), .phy_an_restart(rsa),
    .phy_fef_enable(fef), .phy_power_down(pd), .phy_auto_mdix(amdx),
    .phy_force_mdi(fmdi), .phy_loopback(lpb));
  ppcs_link_partner lp (.clk(clk), .rst(rst), .an_restart(rsa), .tx_disable(txd),
    .auto_mdix(amdx), .force_mdi(fmdi), .mdi_state(mdi), .an_done(an), .link_good(lk),
    .partner_abil(abil), .led_a(la), .led_b(lb));

  // ----------------------------------------------------------------
  // Bench tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  function automatic ppcs_byte_t ad(input int p, input ppcs_byte_t base);
    return base + 8'(p * 16);
  endfunction
  task automatic wr(input ppcs_byte_t a, input ppcs_byte_t d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input ppcs_byte_t a, input ppcs_byte_t e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("rvalid", 8'h01, {7'h00, reg_rvalid});
    chk("rdata", e, reg_rdata);
  endtask
  // The LED pins may be low from the PHY when not blanked, so they are only judged when blanked.
  task automatic outs(input int p);
    logic [7:0] g;
    repeat (2) @(posedge clk);
    #1;
    g = {an_en[p], spd[p], dpx[p], adv[p*5+:5]};
    chk("force_adv_pins", fa[p], g);
    g = {mi[p][7] & led_a[p] & led_b[p], txd[p], rsa[p], ~fef[p], pd[p], ~amdx[p], fmdi[p], lpb[p]};
    chk("misc_pins", mi[p], g);
  endtask
  task automatic put(input int p, input int w, input ppcs_byte_t d);
    if (w == 0) fa[p] = d;
    else mi[p] = d & 8'hDF;
    wr(ad(p, w ? `PPCS_P1_MISC : `PPCS_P1_FORCE_ADV), d);
    outs(p);
    rd(ad(p, w ? `PPCS_P1_MISC : `PPCS_P1_FORCE_ADV), w ? mi[p] : fa[p]);
  endtask
  task automatic stat(input int p);
    repeat (30) @(posedge clk);
    rd(ad(p, `PPCS_P1_STATUS), {mdi[p], an[p], lk[p], abil[p*5+:5]});
  endtask
  task automatic stop_test;
    $display("Checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #2_000_000;
    err_count++;
    stop_test();
  end
  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 16'h0000};
    fa = '{default: 8'hFF};
    mi = '{default: 8'h00};
    void'($urandom(87));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      // Port 2 has linked up by its turn, so only port 1 still shows the reset value.
      rd(ad(p, `PPCS_P1_STATUS), p ? {mdi[p], an[p], lk[p], abil[p*5+:5]} : 8'h00);
      outs(p);
      rd(ad(p, `PPCS_P1_MISC), 8'h00);
      put(p, 0, 8'h00);
      put(p, 0, 8'h60);
      put(p, 0, 8'h9F);
      put(p, 1, 8'hDF);
      put(p, 1, 8'h06);
      stat(p);
      put(p, 1, 8'h00);
      wr(ad(p, `PPCS_P1_MISC), 8'h20);
      n = 0;
      repeat (6) begin
        #1;
        n += int'(rsa[p]);
        @(posedge clk);
      end
      chk("restart_pulses", 8'h01, 8'(n));
      rd(ad(p, `PPCS_P1_MISC), 8'h00);
      stat(p);
    end
    // Writes to status, reserved and unmapped places must leave every control alone.
    foreach (fa[p]) wr(ad(p, `PPCS_P1_STATUS), 8'hFF);
    wr(`PPCS_P3_MISC_RSVD, 8'hFF);
    wr(`PPCS_P3_STAT_RSVD, 8'hFF);
    wr(8'h00, 8'hFF);
    rd(`PPCS_P3_MISC_RSVD, 8'h00);
    rd(`PPCS_P3_STAT_RSVD, 8'h00);
    rd(8'h00, 8'h00);
    outs(0);
    outs(1);
    repeat (24) put(int'($urandom_range(1, 0)), int'($urandom_range(1, 0)), 8'($urandom));
    stat(0);
    stat(1);
    stop_test();
  end
endmodule
